// File: asp_core.sv
// asp_core: full-duplex asynchronous serial port with byte register port
// assumes one clock, wait/stop levels from the power controller, rxd async
//
// Function
// - wait mode runs normally when halt bit clear
// - halt bit plus wait stops internal clocks
// - halt bit leaves tx_on and rx_on alone
// - frames freeze at wait entry when halted
// - frozen frame continues after interrupt wake
// - reset out of wait aborts and resets
// - stop mode freezes logic, keeps registers
// - stop exit by interrupt resumes frames
// - reset out of stop aborts and resets
// - bit rate is clock over sixteen times divisor
// - thirteen-bit divisor across high and low
// - divisor accepts one through 8191
// - generator idle until first enable after reset
// - generator held off for zero divisor
// - high byte held until low byte written
// - reserved locations ignore writes, read zero; control_one bit 2 and control_two bits 7:4 read back as written
// - simultaneous nrz transmit and receive
// - sixteen samples per bit with noise check
// - eight status flags for events
// - one transmit pin, one receive pin
// - eight or nine data bits
// - start, eight or nine data, stop
// - parity in msb, even or odd
// - loop disconnects rxd, source bit chooses path
// - wake by idle line or address mark
`timescale 1ns/10ps
module asp_core
	import asp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic txd_out,
	output logic txd_oe_n,
	input wire logic txd_in,
	input wire logic rxd
);
	typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} asp_state_e;

	// ----------------------------------------
	// clocking of the block
	// ----------------------------------------
	logic [7:0] ctrl_one, ctrl_two, baud_hold;
	logic [12:0] baud_divisor;
	logic clk_on, run;
	// stop mode gates the module clock; wait with the halt bit set only halts the engines
	assign clk_on = ce & ~stop_mode;
	assign run = clk_on & ~(wait_mode & ctrl_one[B_WAIT_HALT]);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	logic wr_ok, tx_dir, brk13, t8;
	assign wr_ok = wr & clk_on;

	// async reset loads every reset value, which also aborts any frame on a
	// reset exit from wait or stop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			baud_hold <= RST_BAUD_HIGH;
			baud_divisor <= {RST_BAUD_HIGH[4:0], RST_BAUD_LOW};
			ctrl_one <= RST_CTRL;
			tx_dir <= 1'b0;
			brk13 <= 1'b0;
			t8 <= 1'b0;
		end else if (wr_ok) begin
			case (addr)
				OFS_BAUD_HIGH: baud_hold <= wdata;
				OFS_BAUD_LOW: baud_divisor <= {baud_hold[4:0], wdata};
				OFS_CTRL_ONE: ctrl_one <= wdata;
				OFS_STAT_TWO: begin
					tx_dir <= wdata[B_TX_DIR];
					brk13 <= wdata[B_BRK13];
				end
				OFS_DATA_HIGH: t8 <= wdata[B_T8];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// baud generator
	// ----------------------------------------
	logic started, tick;
	logic [12:0] bcnt;
	logic gen_on;
	assign gen_on = started & (baud_divisor != 13'h0000) & run;
	assign tick = gen_on & (bcnt == baud_divisor - 13'h0001);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			started <= 1'b0;
		end else if (clk_on && (ctrl_two[B_TX_ON] | ctrl_two[B_RX_ON])) begin
			started <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bcnt <= 13'h0000;
		end else if (clk_on) begin
			if (!started || baud_divisor == 13'h0000) begin
				bcnt <= 13'h0000;
			end else if (run) begin
				bcnt <= tick ? 13'h0000 : bcnt + 13'h0001;
			end
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	asp_state_e tx_st;
	logic [3:0] tx_sub, tx_bit;
	logic [8:0] tx_shift;
	logic [7:0] tx_buf;
	logic tx_empty_flag, tx_done_flag, tx_line, tx_load, nine;
	logic [8:0] tx_word;
	assign nine = ctrl_one[B_NINE];
	// loading waits for a tick so a zero divisor cannot park a start bit on the line
	assign tx_load = tick & (tx_st == S_IDLE) & ctrl_two[B_TX_ON] & ~tx_empty_flag;

	always_comb begin
		tx_word = {t8, tx_buf};
		if (ctrl_one[B_PAR_ON]) begin
			if (nine) begin
				tx_word[8] = ^tx_buf ^ ctrl_one[B_PAR_ODD];
			end else begin
				tx_word[7] = ^tx_buf[6:0] ^ ctrl_one[B_PAR_ODD];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_st <= S_IDLE;
			tx_sub <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 9'h1FF;
		end else if (tx_load) begin
			tx_shift <= tx_word;
			tx_st <= S_START;
			tx_sub <= 4'h0;
			tx_bit <= 4'h0;
		end else if (tick && tx_st != S_IDLE) begin
			tx_sub <= tx_sub + 4'h1;
			if (tx_sub == OVS_LAST) begin
				case (tx_st)
					S_START: tx_st <= S_DATA;
					S_DATA: begin
						tx_shift <= {1'b1, tx_shift[8:1]};
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == (nine ? 4'h8 : 4'h7)) begin
							tx_st <= S_STOP;
						end
					end
					S_STOP: tx_st <= S_IDLE;
					default: tx_st <= S_IDLE;
				endcase
			end
		end
	end

	always_comb begin
		case (tx_st)
			S_START: tx_line = 1'b0;
			S_DATA: tx_line = tx_shift[0];
			S_STOP: tx_line = 1'b1;
			default: tx_line = ~ctrl_two[B_BREAK];
		endcase
	end

	logic tx_end;
	assign tx_end = tick & (tx_st == S_STOP) & (tx_sub == OVS_LAST);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_buf <= 8'h00;
			tx_empty_flag <= 1'b1;
			tx_done_flag <= 1'b1;
		end else if (clk_on) begin
			if (wr_ok && addr == OFS_DATA_LOW) begin
				tx_buf <= wdata;
				tx_empty_flag <= 1'b0;
				tx_done_flag <= 1'b0;
			end else begin
				if (tx_load) begin
					tx_empty_flag <= 1'b1;
				end
				if (tx_end && tx_empty_flag) begin
					tx_done_flag <= 1'b1;
				end
			end
		end
	end

	// single-wire mode only drives the pin while the direction bit says so
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txd_out <= 1'b1;
			txd_oe_n <= 1'b0;
		end else if (clk_on) begin
			txd_out <= tx_line;
			txd_oe_n <= ctrl_one[B_LOOP] & ctrl_one[B_RX_SRC] & ~tx_dir;
		end
	end

	// ----------------------------------------
	// receive input path
	// ----------------------------------------
	logic rxd_s1, rxd_s2, txi_s1, txi_s2, rx_in;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			txi_s1 <= 1'b1;
			txi_s2 <= 1'b1;
		end else if (clk_on) begin
			rxd_s1 <= rxd;
			rxd_s2 <= rxd_s1;
			txi_s1 <= txd_in;
			txi_s2 <= txi_s1;
		end
	end

	always_comb begin
		if (!ctrl_one[B_LOOP]) begin
			rx_in = rxd_s2;
		end else if (ctrl_one[B_RX_SRC]) begin
			rx_in = txi_s2;
		end else begin
			rx_in = tx_line;
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	asp_state_e rx_st;
	logic [3:0] rx_sub, rx_bit;
	logic [8:0] rx_shift;
	logic vote_a, vote_b, rx_noise, rx_done, rx_ferr, bit_val, bit_noisy;
	assign bit_val = (vote_a & vote_b) | (vote_a & rx_in) | (vote_b & rx_in);
	assign bit_noisy = ~(vote_a == vote_b && vote_b == rx_in);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_st <= S_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift <= 9'h000;
			vote_a <= 1'b1;
			vote_b <= 1'b1;
			rx_noise <= 1'b0;
			rx_done <= 1'b0;
			rx_ferr <= 1'b0;
		end else if (run) begin
			rx_done <= 1'b0;
			if (tick && ctrl_two[B_RX_ON]) begin
				rx_sub <= rx_sub + 4'h1;
				if (rx_sub == VOTE_A) begin
					vote_a <= rx_in;
				end
				if (rx_sub == VOTE_B) begin
					vote_b <= rx_in;
				end
				case (rx_st)
					S_IDLE: begin
						rx_sub <= 4'h1;
						if (!rx_in) begin
							rx_st <= S_START;
							rx_noise <= 1'b0;
							rx_bit <= 4'h0;
						end
					end
					S_START: if (rx_sub == VOTE_C) begin
						rx_noise <= bit_noisy;
						if (bit_val) begin
							rx_st <= S_IDLE;
						end
					end else if (rx_sub == OVS_LAST) begin
						rx_st <= S_DATA;
					end
					S_DATA: if (rx_sub == VOTE_C) begin
						rx_noise <= rx_noise | bit_noisy;
						rx_shift <= nine ? {bit_val, rx_shift[8:1]} :
							{1'b0, bit_val, rx_shift[7:1]};
					end else if (rx_sub == OVS_LAST) begin
						rx_bit <= rx_bit + 4'h1;
						if (rx_bit == (nine ? 4'h8 : 4'h7)) begin
							rx_st <= S_STOP;
						end
					end
					S_STOP: if (rx_sub == VOTE_C) begin
						// stop ends mid-bit so the next start edge is not missed
						rx_noise <= rx_noise | bit_noisy;
						rx_ferr <= ~bit_val;
						rx_done <= 1'b1;
						rx_st <= S_IDLE;
					end
					default: rx_st <= S_IDLE;
				endcase
			end else if (!ctrl_two[B_RX_ON]) begin
				rx_st <= S_IDLE;
			end
		end
	end

	// ----------------------------------------
	// receive flags, wake-up and idle line
	// ----------------------------------------
	logic [8:0] rx_buf;
	logic rx_full_flag, ovr_flag, noise_flag, framing_err_flag, parity_err_flag;
	logic idle_flag, idle_armed, rx_wake, sr1_seen, clr_rx, rx_accept, idle_hit, msb_one;
	logic [7:0] idle_cnt;
	assign msb_one = nine ? rx_shift[8] : rx_shift[7];
	// address mark frame both wakes the receiver and is taken in
	// rx_done stays high through a halted wait, so the frame is taken only while running
	assign rx_accept = run & rx_done &
		(~ctrl_two[B_RX_WAKE] | (ctrl_one[B_WAKE] & msb_one));
	assign clr_rx = rd & clk_on & (addr == OFS_DATA_LOW) & sr1_seen;
	assign idle_hit = tick & (rx_st == S_IDLE) & rx_in &
		(idle_cnt == (nine ? IDLE_TICKS_9 : IDLE_TICKS_8) - 8'h01);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idle_cnt <= 8'h00;
		end else if (run) begin
			if (rx_st != S_IDLE || !rx_in) begin
				idle_cnt <= 8'h00;
			end else if (tick && !idle_hit) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sr1_seen <= 1'b0;
		end else if (rd && clk_on) begin
			sr1_seen <= (addr == OFS_STAT_ONE) | (sr1_seen & addr != OFS_DATA_LOW);
		end
	end

	// set wins over the software clear in every flag below but ovr_flag, which a clear in the same cycle keeps low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_buf <= 9'h000;
			rx_full_flag <= 1'b0;
			ovr_flag <= 1'b0;
			noise_flag <= 1'b0;
			framing_err_flag <= 1'b0;
			parity_err_flag <= 1'b0;
			idle_flag <= 1'b0;
			idle_armed <= 1'b0;
		end else if (clk_on) begin
			if (clr_rx) begin
				rx_full_flag <= 1'b0;
				ovr_flag <= 1'b0;
				noise_flag <= 1'b0;
				framing_err_flag <= 1'b0;
				parity_err_flag <= 1'b0;
				idle_flag <= 1'b0;
			end
			if (rx_accept && rx_full_flag && !clr_rx) begin
				ovr_flag <= 1'b1;
			end else if (rx_accept) begin
				rx_buf <= rx_shift;
				rx_full_flag <= 1'b1;
				noise_flag <= rx_noise;
				framing_err_flag <= rx_ferr;
				parity_err_flag <= ctrl_one[B_PAR_ON] &
					(^(nine ? rx_shift : {1'b0, rx_shift[7:0]}) ^ ctrl_one[B_PAR_ODD]);
			end
			if (rx_done) begin
				idle_armed <= 1'b1;
			end else if (idle_hit && idle_armed) begin
				idle_flag <= ~ctrl_two[B_RX_WAKE];
				idle_armed <= 1'b0;
			end
		end
	end

	// control_two, with the wake bit cleared by hardware
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_two <= RST_CTRL;
		end else if (clk_on) begin
			if (wr_ok && addr == OFS_CTRL_TWO) begin
				ctrl_two <= wdata;
			end else if ((idle_hit && !ctrl_one[B_WAKE]) || (rx_done && rx_accept)) begin
				ctrl_two[B_RX_WAKE] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register reads, answered one cycle later
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (clk_on) begin
			rdata <= 8'h00;
			if (rd) begin
				case (addr)
					OFS_BAUD_HIGH: rdata <= {3'h0, baud_divisor[12:8]};
					OFS_BAUD_LOW: rdata <= baud_divisor[7:0];
					OFS_CTRL_ONE: rdata <= ctrl_one;
					OFS_CTRL_TWO: rdata <= ctrl_two;
					OFS_STAT_ONE: rdata <= {tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag,
						ovr_flag, noise_flag, framing_err_flag, parity_err_flag};
					OFS_STAT_TWO: rdata <= {5'h00, brk13, tx_dir, rx_st != S_IDLE};
					OFS_DATA_HIGH: rdata <= {rx_buf[8], t8, 6'h00};
					OFS_DATA_LOW: rdata <= rx_buf[7:0];
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	wait_runs_a: assert property (@(posedge clk) disable iff (!nrst)
		(ce && !stop_mode && !ctrl_one[B_WAIT_HALT]) |-> run)
		else $error("port halted in wait with halt bit clear");
	halt_freeze_a: assert property (@(posedge clk) disable iff (!nrst)
		(!run ##1 !run) |-> ($stable(tx_sub) && $stable(rx_sub) && $stable(bcnt)))
		else $error("frame moved while halted");
	zero_div_a: assert property (@(posedge clk) disable iff (!nrst)
		(baud_divisor == 13'h0000) |-> !tick)
		else $error("baud tick with zero divisor");
	not_started_a: assert property (@(posedge clk) disable iff (!nrst)
		!started |-> (!tick && tx_st == S_IDLE))
		else $error("generator active before first enable");
	high_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(wr_ok && addr == OFS_BAUD_HIGH) |=> $stable(baud_divisor))
		else $error("high byte write changed divisor");
	resv_read_a: assert property (@(posedge clk) disable iff (!nrst)
		(rd && clk_on && addr == OFS_STAT_TWO) |=> (rdata[7:3] == 5'h00))
		else $error("reserved bits read nonzero");
	rx_full_a: assert property (@(posedge clk) disable iff (!nrst)
		(rx_accept && !rx_full_flag && clk_on) |=> (rx_full_flag && rx_buf == $past(rx_shift)))
		else $error("accepted frame not stored");
	overrun_a: assert property (@(posedge clk) disable iff (!nrst)
		(rx_accept && rx_full_flag && !clr_rx && clk_on) |=> (ovr_flag && $stable(rx_buf)))
		else $error("overrun not flagged or data lost");
	loop_path_a: assert property (@(posedge clk) disable iff (!nrst)
		(ctrl_one[B_LOOP] && !ctrl_one[B_RX_SRC]) |-> (rx_in == tx_line))
		else $error("loop path not internal");
	start_bit_a: assert property (@(posedge clk) disable iff (!nrst)
		(tx_load && clk_on) |=> (tx_st == S_START && tx_empty_flag) ##1 (txd_out == 1'b0))
		else $error("start bit not sent after load");

endmodule // asp_core

// File: asp_peer.sv
// asp_peer: remote serial transceiver facing the port's pins
// assumes the testbench calls its tasks from one process; its line idles high
`timescale 1ns/10ps
module asp_peer (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	int bit_clks = 16;

	initial rxd = 1'b1;

	task automatic hold(input logic lv);
		@(posedge clk);
		rxd <= lv;
	endtask

	// same rate as the port; length and any parity bit come from the caller, lsb first
	task automatic send(input logic [8:0] d, input int nb, input logic bad_stop,
		input logic glitch);
		int i;
		@(posedge clk);
		rxd <= 1'b0;
		repeat (bit_clks) @(posedge clk);
		for (i = 0; i < nb; i++) begin
			rxd <= d[i];
			if (i == 0 && glitch) begin
				// one flipped cycle mid bit 0 hits only the middle vote
				repeat (bit_clks / 2) @(posedge clk);
				rxd <= ~d[0];
				@(posedge clk);
				rxd <= d[0];
				repeat (bit_clks / 2 - 1) @(posedge clk);
			end else begin
				repeat (bit_clks) @(posedge clk);
			end
		end
		// a broken stop bit only when a scenario asks for one
		rxd <= ~bad_stop;
		repeat (bit_clks) @(posedge clk);
		rxd <= 1'b1;
	endtask

	// samples mid-bit, lsb first
	task automatic recv(input int nb, output logic [8:0] d, output logic ok);
		int i;
		d = 9'h000;
		ok = 1'b0;
		for (i = 0; i < 4000 && txd !== 1'b0; i++) @(posedge clk);
		if (txd !== 1'b0) return;
		repeat (bit_clks / 2) @(posedge clk);
		for (i = 0; i < nb; i++) begin
			repeat (bit_clks) @(posedge clk);
			d[i] = txd;
		end
		repeat (bit_clks) @(posedge clk);
		ok = (txd === 1'b1);
	endtask
endmodule // asp_peer

// File: asp_pkg.sv
// asp_pkg: constants shared by the asynchronous serial port
// assumes byte-wide register port with 3-bit offsets
package asp_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [2:0] OFS_BAUD_HIGH = 3'h0;
	localparam logic [2:0] OFS_BAUD_LOW = 3'h1;
	localparam logic [2:0] OFS_CTRL_ONE = 3'h2;
	localparam logic [2:0] OFS_CTRL_TWO = 3'h3;
	localparam logic [2:0] OFS_STAT_ONE = 3'h4;
	localparam logic [2:0] OFS_STAT_TWO = 3'h5;
	localparam logic [2:0] OFS_DATA_HIGH = 3'h6;
	localparam logic [2:0] OFS_DATA_LOW = 3'h7;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	// control_one
	localparam int B_LOOP = 7;
	localparam int B_WAIT_HALT = 6;
	localparam int B_RX_SRC = 5;
	localparam int B_NINE = 4;
	localparam int B_WAKE = 3;
	localparam int B_PAR_ON = 1;
	localparam int B_PAR_ODD = 0;
	// control_two
	localparam int B_TX_ON = 3;
	localparam int B_RX_ON = 2;
	localparam int B_RX_WAKE = 1;
	localparam int B_BREAK = 0;
	// status_two
	localparam int B_TX_DIR = 1;
	localparam int B_BRK13 = 2;
	// data_high
	localparam int B_T8 = 6;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
	localparam logic [7:0] RST_BAUD_LOW = 8'h04;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] VOTE_A = 4'h7;
	localparam logic [3:0] VOTE_B = 4'h8;
	localparam logic [3:0] VOTE_C = 4'h9;
	localparam logic [7:0] IDLE_TICKS_8 = 8'hA0;
	localparam logic [7:0] IDLE_TICKS_9 = 8'hB0;
endpackage

// File: testbench.sv
// testbench: self-checking bench for asp_core with a remote peer model
// assumes asp_pkg offsets; divisor 1 or 2 keeps frames short
`timescale 1ns/10ps
module testbench
	import asp_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic txd_out;
	logic txd_oe_n;
	logic txd_pin;
	logic rxd;
	int errors = 0;
	int checked = 0;

	always #2.5 clk = ~clk;
	// pin pulled up whenever the port lets go of it
	assign txd_pin = txd_oe_n ? 1'b1 : txd_out;

	asp_core DUT (.clk(clk), .nrst(nrst), .ce(ce), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .txd_in(txd_pin),
		.rxd(rxd));
	asp_peer peer (.clk(clk), .txd(txd_pin), .rxd(rxd));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic close_out();
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_reset();
		@(posedge clk);
		nrst <= 1'b0;
		wait_mode <= 1'b0;
		stop_mode <= 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
	endtask

	task automatic setup(input logic [12:0] div, input logic [7:0] c1, input logic [7:0] c2);
		peer.bit_clks = 16 * int'(div);
		wr_reg(OFS_BAUD_HIGH, {3'h0, div[12:8]});
		wr_reg(OFS_BAUD_LOW, div[7:0]);
		wr_reg(OFS_CTRL_ONE, c1);
		wr_reg(OFS_CTRL_TWO, c2);
	endtask

	task automatic wait_flag(input int bitn);
		logic [7:0] s;
		int i;
		for (i = 0; i < 3000; i++) begin
			rd_reg(OFS_STAT_ONE, s);
			if (s[bitn] === 1'b1) return;
		end
		errors++;
		$display("ERROR %0t: status bit %0d never set", $time, bitn);
		close_out();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic reg_case();
		logic [7:0] v;
		logic [8:0] got;
		logic ok;
		rd_reg(OFS_BAUD_HIGH, v);
		check(9'(v), 9'(RST_BAUD_HIGH));
		rd_reg(OFS_BAUD_LOW, v);
		check(9'(v), 9'(RST_BAUD_LOW));
		rd_reg(OFS_STAT_ONE, v);
		check(9'(v), 9'h0C0);
		peer.bit_clks = 16;
		wr_reg(OFS_BAUD_HIGH, 8'h00);
		wr_reg(OFS_BAUD_LOW, 8'h01);
		wr_reg(OFS_BAUD_HIGH, 8'h01);
		wr_reg(OFS_CTRL_TWO, 8'h08);
		wr_reg(OFS_DATA_LOW, 8'h5A);
		peer.recv(8, got, ok);
		check(9'(ok), 9'h001);
		check(got, 9'h05A);
		wait_flag(6);
		wr_reg(OFS_BAUD_LOW, 8'h01);
		rd_reg(OFS_BAUD_HIGH, v);
		check(9'(v), 9'h001);
		wr_reg(OFS_BAUD_HIGH, 8'hFF);
		wr_reg(OFS_BAUD_LOW, 8'hFF);
		rd_reg(OFS_BAUD_HIGH, v);
		check(9'(v), 9'h01F);
		wr_reg(OFS_STAT_ONE, 8'h00);
		rd_reg(OFS_STAT_ONE, v);
		check(9'(v), 9'h0C0);
		wr_reg(OFS_DATA_HIGH, 8'hFF);
		rd_reg(OFS_DATA_HIGH, v);
		check(9'(v & 8'h3F), 9'h000);
		do_reset();
	endtask

	task automatic tx_case(input logic [12:0] div, input logic [7:0] c1, input logic t8,
		input logic [7:0] d, input int nb, input logic [8:0] exp);
		logic [8:0] got;
		logic ok;
		setup(div, c1, 8'h08);
		wr_reg(OFS_DATA_HIGH, {1'b0, t8, 6'h00});
		wr_reg(OFS_DATA_LOW, d);
		peer.recv(nb, got, ok);
		check(9'(ok), 9'h001);
		check(got, exp);
	endtask

	task automatic rx_case(input logic [7:0] c1, input logic [8:0] d, input logic bad,
		input logic noisy, input logic [7:0] flags);
		logic [7:0] v;
		setup(13'h0001, c1, 8'h04);
		peer.send(d, 8, bad, noisy);
		wait_flag(5);
		rd_reg(OFS_STAT_ONE, v);
		check(9'(v & 8'h27), 9'(flags));
		rd_reg(OFS_DATA_LOW, v);
		check(9'(v), {1'b0, d[7:0]});
	endtask

	task automatic loop_case();
		logic [7:0] v;
		setup(13'h0001, 8'h80, 8'h0C);
		check(9'(txd_oe_n), 9'h000);
		peer.hold(1'b0);
		wr_reg(OFS_DATA_LOW, 8'h96);
		wait_flag(5);
		rd_reg(OFS_DATA_LOW, v);
		check(9'(v), 9'h096);
		peer.hold(1'b1);
		wr_reg(OFS_CTRL_ONE, 8'hA0);
		@(posedge clk);
		#1 check(9'(txd_oe_n), 9'h001);
	endtask

	task automatic zero_case();
		int i;
		int lows;
		lows = 0;
		setup(13'h0000, 8'h00, 8'h08);
		wr_reg(OFS_DATA_LOW, 8'h00);
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if (txd_pin !== 1'b1) lows++;
		end
		check(9'(lows), 9'h000);
		do_reset();
	endtask

	// all-zero data keeps the line low through the freeze, so a restart or
	// an abandoned frame changes the count of low cycles seen while running
	task automatic halt_case(input logic use_stop, input logic by_reset);
		int i;
		int lows;
		int changes;
		logic held;
		logic [7:0] v;
		lows = 0;
		changes = 0;
		held = 1'b1;
		setup(13'h0001, use_stop ? 8'h00 : 8'h40, 8'h0C);
		wr_reg(OFS_DATA_LOW, 8'h00);
		for (i = 0; i < 600; i++) begin
			@(posedge clk);
			if (i == 110 && by_reset) break;
			if (i == 40) begin
				wait_mode <= !use_stop;
				stop_mode <= use_stop;
			end
			if (i == 110) begin
				wait_mode <= 1'b0;
				stop_mode <= 1'b0;
			end
			// look once the edge has settled, never in its own time step
			#1;
			if (i == 40) held = txd_pin;
			if (!(wait_mode || stop_mode) && txd_pin === 1'b0) lows++;
			if ((wait_mode || stop_mode) && txd_pin !== held) changes++;
		end
		check(9'(changes), 9'h000);
		if (by_reset) begin
			do_reset();
			check(9'(txd_pin), 9'h001);
			rd_reg(OFS_STAT_ONE, v);
			check(9'(v), 9'h0C0);
			rd_reg(OFS_BAUD_LOW, v);
			check(9'(v), 9'h004);
		end else begin
			check(9'(lows), 9'h090);
			rd_reg(OFS_CTRL_TWO, v);
			check(9'(v), 9'h00C);
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		reg_case();
		tx_case(13'h0002, 8'h00, 1'b0, 8'hA5, 8, 9'h0A5);
		tx_case(13'h0001, 8'h02, 1'b0, 8'h03, 8, 9'h003);
		tx_case(13'h0001, 8'h02, 1'b0, 8'h07, 8, 9'h087);
		tx_case(13'h0001, 8'h03, 1'b0, 8'h07, 8, 9'h007);
		tx_case(13'h0001, 8'h10, 1'b1, 8'h55, 9, 9'h155);
		wait_mode <= 1'b1;
		tx_case(13'h0001, 8'h00, 1'b0, 8'hC3, 8, 9'h0C3);
		wait_mode <= 1'b0;
		rx_case(8'h00, 9'h03C, 1'b0, 1'b0, 8'h20);
		rx_case(8'h00, 9'h033, 1'b1, 1'b0, 8'h22);
		rx_case(8'h02, 9'h001, 1'b0, 1'b0, 8'h21);
		rx_case(8'h00, 9'h05A, 1'b0, 1'b1, 8'h24);
		loop_case();
		zero_case();
		halt_case(1'b0, 1'b0);
		halt_case(1'b1, 1'b0);
		halt_case(1'b0, 1'b1);
		halt_case(1'b1, 1'b1);
		close_out();
	end
endmodule // testbench
